//--- pkg/otp_prog_params.svh
/*
 Timing counts and encodings for the code-memory programmer.
 Assumes a 100 MHz clock; included by the package and the main module.
*/
`ifndef OTP_PROG_PARAMS_SVH
`define OTP_PROG_PARAMS_SVH
`define CLK_PERIOD_NS       10
`define SETUP_TIME_NS       1000
`define SETUP_CYCLES        ((`SETUP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define VOLT_SETTLE_NS      2000
`define VOLT_SETTLE_CYCLES  ((`VOLT_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PULSE_TIME_NS       100000
`define PULSE_CYCLES_DEF    ((`PULSE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_TIME_NS        500
`define READ_CYCLES         ((`READ_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ADDR_WIDTH          13
`define DATA_WIDTH          8
`define ERASED_BYTE         8'hff
`define CTRL_WIDTH          4
`define CTRL_PROGRAM        4'h1
`define CTRL_VERIFY         4'h2
`define CTRL_IDLE           4'h0
`define FIFO_DEPTH          32
`endif

//--- pkg/otp_prog_pkg.sv
/*
 Types shared by the programmer: command word and result word.
 Assumes otp_prog_params.svh is on the include path.
*/
`include "otp_prog_params.svh"
package otp_prog_pkg;
	typedef enum logic {op_program, op_verify} op_t;
	typedef struct packed {
		op_t                     op;
		logic [`ADDR_WIDTH-1:0]  addr;
		logic [`DATA_WIDTH-1:0]  data;
	} cmd_t;
	typedef struct packed {
		logic [`ADDR_WIDTH-1:0]  addr;
		logic [`DATA_WIDTH-1:0]  data;
		logic                    mismatch;
		logic                    erased;
	} result_t;
endpackage

//--- verilog/cmd_fifo.sv
/*
 Synchronous FIFO with valid/ready on both sides and registered read data.
 Assumes a single clock and active-low asynchronous reset.
*/
`timescale 1ns/1ps
module cmd_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input  wire logic             clock,
	input  wire logic             reset_n,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	wire              push = in_valid && in_ready;
	wire              pop  = out_valid && out_ready;
	wire              load = (count != '0) && (!out_valid || pop);
	wire              stored_pop = load;
	wire [AW:0]       next_count = count + (push ? 1'b1 : 1'b0) - (stored_pop ? 1'b1 : 1'b0);
	// The output register counts toward depth, so the queue never holds more than DEPTH words
	wire              next_out_valid = load || (out_valid && !pop);
	wire [AW:0]       next_total = next_count + {{AW{1'b0}}, next_out_valid};

	always_ff @(posedge clock) begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			wr_ptr    <= '0;
			rd_ptr    <= '0;
			count     <= '0;
			in_ready  <= 1'b1;
			out_valid <= 1'b0;
			out_data  <= '0;
		end else begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (stored_pop) begin
				rd_ptr   <= rd_ptr + 1'b1;
				out_data <= mem[rd_ptr];
			end
			if (load)
				out_valid <= 1'b1;
			else if (pop)
				out_valid <= 1'b0;
			count    <= next_count;
			in_ready <= (next_total < (AW+1)'(DEPTH));
		end
	end
endmodule

//--- verilog/otp_programmer.sv
/*
 Programmer that drives the device's code-memory program and verify pins.
 Commands arrive through a 32-word FIFO; one result leaves per command.
 Assumes an external analog switch turns program_voltage_input into the high voltage.
*/
`timescale 1ns/1ps
`include "otp_prog_params.svh"
// Notes on behaviour
// [RULE1] One strobe pulse programs each byte
// [RULE2] Control mode, then address, then data
// [RULE3] Raise program voltage after address and data
// [RULE4] Exactly one strobe while voltage high
// [RULE5] Lower voltage before the next address
// [RULE6] Repeat sequence for every address
// [RULE7] Read back and compare after each byte
// [RULE8] Output-enable pin gates device data drive
// [RULE9] Verify mode plus address returns stored byte
// [RULE10] Verify repeats address and read per address
// [RULE11] Encryption array has no direct read
// [RULE12] Erasure clears code, encryption and lock
// [RULE13] Erased bytes read as all ones
// [RULE14] Pins held stable across voltage and strobe
module otp_programmer #(
	parameter int PULSE_CYCLES = `PULSE_CYCLES_DEF
) (
	input  wire logic                     clock,
	input  wire logic                     reset_n,
	input  wire otp_prog_pkg::cmd_t       cmd,
	input  wire logic                     cmd_valid,
	output logic                          cmd_ready,
	output otp_prog_pkg::result_t         result,
	output logic                          result_valid,
	input  wire logic                     result_ready,
	output logic                          busy,
	output logic [`CTRL_WIDTH-1:0]        control_pins,
	output logic [`ADDR_WIDTH-1:0]        address_pins,
	output logic [`DATA_WIDTH-1:0]        data_out,
	output logic                          data_oe_n,
	input  wire logic [`DATA_WIDTH-1:0]   data_in,
	output logic                          read_enable_n,
	output logic                          program_voltage_input,
	output logic                          latch_or_program_strobe
);
	typedef enum logic [3:0] {
		st_idle, st_mode, st_addr, st_data, st_vpp_up, st_pulse,
		st_vpp_down, st_rd_mode, st_rd_sample, st_report
	} state_t;

	state_t                    state;
	state_t                    next_state;
	logic [31:0]               timer;
	otp_prog_pkg::cmd_t        cur;
	otp_prog_pkg::cmd_t        q_cmd;
	logic                      q_valid;
	logic                      q_ready;

	cmd_fifo #(
		.WIDTH ($bits(otp_prog_pkg::cmd_t)),
		.DEPTH (`FIFO_DEPTH)
	) u_fifo (
		.clock     (clock),
		.reset_n   (reset_n),
		.in_data   (cmd),
		.in_valid  (cmd_valid),
		.in_ready  (cmd_ready),
		.out_data  (q_cmd),
		.out_valid (q_valid),
		.out_ready (q_ready)
	);

	wire timer_done = (timer == 32'h0);
	wire is_program = (cur.op == otp_prog_pkg::op_program);
	// Results stall the FIFO so a slow consumer back-pressures the source
	assign q_ready = (state == st_idle) && !result_valid;
	wire take = q_ready && q_valid;
	wire [`DATA_WIDTH-1:0] sampled = data_in;
	wire cmp_bad = is_program && (sampled != cur.data);

	always_comb begin
		next_state = state;
		case (state)
			st_idle: begin
				if (take)
					next_state = st_mode;
			end
			st_mode: begin
				if (timer_done)
					next_state = is_program ? st_addr : st_rd_mode;
			end
			st_addr: begin
				if (timer_done)
					next_state = st_data;
			end
			st_data: begin
				if (timer_done)
					next_state = st_vpp_up;
			end
			st_vpp_up: begin
				if (timer_done)
					next_state = st_pulse;
			end
			// One pulse only: the pulse step always leads on to the voltage-lowering step, never back to raising it
			st_pulse: begin
				if (timer_done)
					next_state = st_vpp_down; // RULE1
			end
			st_vpp_down: begin
				if (timer_done)
					next_state = st_rd_mode; // RULE7
			end
			st_rd_mode: begin
				if (timer_done)
					next_state = st_rd_sample;
			end
			st_rd_sample: next_state = st_report;
			st_report:    next_state = st_idle;
			default:      next_state = st_idle;
		endcase
	end

	wire [31:0] load_time =
		(next_state == st_pulse)    ? 32'(PULSE_CYCLES - 1) :
		(next_state == st_vpp_up)   ? 32'(`VOLT_SETTLE_CYCLES - 1) :
		(next_state == st_vpp_down) ? 32'(`VOLT_SETTLE_CYCLES - 1) :
		(next_state == st_rd_mode)  ? 32'(`READ_CYCLES - 1) :
		32'(`SETUP_CYCLES - 1);

	// Each step reloads its count on entry, then counts down to zero and waits there
	wire                     step_change = (next_state != state);
	wire [31:0]              next_timer  = step_change ? load_time :
		timer_done ? timer : timer - 32'h1;
	wire otp_prog_pkg::cmd_t next_cur    = take ? q_cmd : cur;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state <= st_idle;
			timer <= 32'h0;
			cur   <= '0;
		end else begin
			state <= next_state;
			timer <= next_timer;
			cur   <= next_cur;
		end
	end

	// Command in hand on step entry: the queue head while idle, else the latched one
	wire is_program_next = (state == st_idle) ? (q_cmd.op == otp_prog_pkg::op_program)
		: is_program;

	// Step-entry decode; a pin moves only on entry to the step that owns it
	wire enter_idle    = (next_state == st_idle);
	wire enter_mode    = (next_state == st_mode);
	wire enter_addr    = (next_state == st_addr);
	wire enter_data    = (next_state == st_data);
	wire enter_vpp_up  = (next_state == st_vpp_up);
	wire enter_pulse   = (next_state == st_pulse);
	wire enter_vpp_dn  = (next_state == st_vpp_down);
	wire enter_rd_mode = (next_state == st_rd_mode);

	// Each step keeps what earlier steps set, so only the strobe moves under high voltage
	wire [`CTRL_WIDTH-1:0] next_control_pins =
		enter_mode    ? (is_program_next ? `CTRL_PROGRAM : `CTRL_VERIFY) : // RULE2 RULE9
		enter_rd_mode ? `CTRL_VERIFY : // RULE7
		enter_idle    ? `CTRL_IDLE :
		control_pins;
	wire [`ADDR_WIDTH-1:0] next_address_pins =
		enter_addr    ? cur.addr : // RULE2 RULE6
		enter_rd_mode ? cur.addr : // RULE10
		address_pins;
	wire [`DATA_WIDTH-1:0] next_data_out = enter_data ? cur.data : data_out; // RULE2
	// Release data lines no later than the cycle in which the device may start to drive them
	wire next_data_oe_n =
		enter_data                    ? 1'b0 :
		(enter_mode || enter_rd_mode) ? 1'b1 : // RULE8
		data_oe_n;
	wire next_read_enable_n =
		enter_rd_mode              ? 1'b0 : // RULE8 RULE9
		(enter_mode || enter_idle) ? 1'b1 :
		read_enable_n;
	wire next_program_voltage =
		enter_vpp_up ? 1'b1 : // RULE3 RULE14
		enter_vpp_dn ? 1'b0 : // RULE5
		program_voltage_input;
	wire next_strobe =
		enter_pulse  ? 1'b0 : // RULE1 RULE4
		enter_vpp_dn ? 1'b1 : // RULE4
		latch_or_program_strobe;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			control_pins            <= `CTRL_IDLE;
			address_pins            <= '0;
			data_out                <= '0;
			data_oe_n               <= 1'b1;
			read_enable_n           <= 1'b1;
			program_voltage_input   <= 1'b0;
			latch_or_program_strobe <= 1'b1;
			busy                    <= 1'b0;
		end else begin
			control_pins            <= next_control_pins;
			address_pins            <= next_address_pins;
			data_out                <= next_data_out;
			data_oe_n               <= next_data_oe_n;
			read_enable_n           <= next_read_enable_n;
			program_voltage_input   <= next_program_voltage;
			latch_or_program_strobe <= next_strobe;
			busy                    <= !enter_idle;
		end
	end

	// Compare in the same cycle the bus is sampled; erased value flags blank cells
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			result       <= '0;
			result_valid <= 1'b0;
		end else if (state == st_rd_sample) begin
			result.addr     <= cur.addr; // RULE9
			result.data     <= sampled; // RULE9
			result.mismatch <= cmp_bad; // RULE7
			result.erased   <= (sampled == `ERASED_BYTE); // RULE13
			result_valid    <= 1'b1;
		end else if (result_ready) begin
			result_valid <= 1'b0;
		end
	end
endmodule

//--- test/otp_device_model.sv
/*
 Behavioural code memory that answers the programmer's pins.
 Assumes it is wired to otp_programmer outputs in tb.
*/
`timescale 1ns/1ps
`include "otp_prog_params.svh"
module otp_device_model (
	input  wire logic                   clock,
	input  wire logic [`CTRL_WIDTH-1:0] control_pins,
	input  wire logic [`ADDR_WIDTH-1:0] address_pins,
	input  wire logic [`DATA_WIDTH-1:0] data_out,
	input  wire logic                   data_oe_n,
	input  wire logic                   read_enable_n,
	input  wire logic                   program_voltage_input,
	input  wire logic                   latch_or_program_strobe,
	output logic [`DATA_WIDTH-1:0]      data_in
);
	// Code array only: encryption bits have no read path
	logic [`DATA_WIDTH-1:0] mem [0:8191];
	logic [`DATA_WIDTH-1:0] last = 8'h5a;
	wire                    drive = !read_enable_n && control_pins == `CTRL_VERIFY;
	initial foreach (mem[i]) mem[i] = `ERASED_BYTE;
	// Written while the pulse is low under high voltage, sampled on the clock so the
	// falling voltage cannot race the strobe's rising edge; programming only clears bits
	always @(posedge clock)
		if (!latch_or_program_strobe && program_voltage_input
				&& control_pins == `CTRL_PROGRAM && !data_oe_n)
			mem[address_pins] <= mem[address_pins] & data_out;
	// Released bus alternates the last driven byte with its inverse, so a stale byte is never held steady
	always @(posedge clock)
		last <= drive ? mem[address_pins] : ~last;
	assign data_in = drive ? mem[address_pins] : last;
endmodule

//--- test/otp_programmer_assertions.sv
/*
 Checker for the programmer's device pins and result port.
 Assumes it is bound to otp_programmer.
*/
`timescale 1ns/1ps
`include "otp_prog_params.svh"
module otp_prog_checker #(
	parameter int PULSE_CYCLES = `PULSE_CYCLES_DEF
) (
	input wire logic                   clock,
	input wire logic                   reset_n,
	input wire otp_prog_pkg::result_t  result,
	input wire logic                   result_valid,
	input wire logic                   result_ready,
	input wire logic [`CTRL_WIDTH-1:0] control_pins,
	input wire logic [`ADDR_WIDTH-1:0] address_pins,
	input wire logic [`DATA_WIDTH-1:0] data_out,
	input wire logic                   data_oe_n,
	input wire logic                   read_enable_n,
	input wire logic                   program_voltage_input,
	input wire logic                   latch_or_program_strobe
);
	int low_cnt;
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			low_cnt <= 0;
		else
			low_cnt <= latch_or_program_strobe ? 0 : low_cnt + 1;
	end
	AST_STROBE_VPP: assert property (!latch_or_program_strobe |-> program_voltage_input)
		else $error("strobe without voltage");
	AST_STROBE_MODE: assert property (!latch_or_program_strobe |->
		control_pins == `CTRL_PROGRAM && !data_oe_n) else $error("strobe outside program");
	AST_VPP_DATA: assert property (program_voltage_input |-> !data_oe_n && read_enable_n)
		else $error("voltage without data");
	AST_PINS_STABLE: assert property (program_voltage_input && $past(program_voltage_input)
		|-> $stable(address_pins) && $stable(data_out) && $stable(control_pins))
		else $error("pins moved under voltage");
	AST_ONE_PULSE: assert property ($rose(latch_or_program_strobe) |->
		latch_or_program_strobe throughout (##[0:400] !program_voltage_input))
		else $error("second pulse or voltage kept");
	AST_PULSE_WIDTH: assert property ($rose(latch_or_program_strobe) |-> low_cnt == PULSE_CYCLES)
		else $error("pulse width wrong");
	AST_READ_GATED: assert property (!read_enable_n |->
		data_oe_n && control_pins == `CTRL_VERIFY) else $error("read enable outside verify");
	AST_RESULT_HOLD: assert property (result_valid && !result_ready |=>
		result_valid && $stable(result)) else $error("result dropped");
endmodule
bind otp_programmer otp_prog_checker #(.PULSE_CYCLES(PULSE_CYCLES)) u_otp_prog_checker (.*);

//--- test/tb.sv
/*
 Self-checking bench: programmer against a behavioural device.
 Assumes the checker binds itself from its own file.
*/
`timescale 1ns/1ps
`include "otp_prog_params.svh"
module tb;
	logic                  clock = 0;
	logic                  reset_n = 0;
	otp_prog_pkg::cmd_t    cmd = '0;
	logic                  cmd_valid = 0;
	logic                  cmd_ready, result_valid, data_oe_n, read_enable_n;
	logic                  program_voltage_input, latch_or_program_strobe, ok, busy;
	logic                  result_ready = 0;
	otp_prog_pkg::result_t result, r;
	logic [3:0]            control_pins;
	logic [12:0]           address_pins;
	logic [7:0]            data_out, data_in;
	int                    error_cnt = 0;
	int                    checked = 0;
	int                    k;
	always #5 clock = ~clock;
	otp_programmer #(.PULSE_CYCLES(5)) u_otp_programmer (.clock, .reset_n, .cmd, .cmd_valid,
		.cmd_ready, .result, .result_valid, .result_ready, .busy, .control_pins,
		.address_pins, .data_out, .data_oe_n, .data_in, .read_enable_n,
		.program_voltage_input, .latch_or_program_strobe);
	otp_device_model u_otp_device_model (.clock, .control_pins, .address_pins, .data_out,
		.data_oe_n, .read_enable_n, .program_voltage_input, .latch_or_program_strobe, .data_in);
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Withdraws a refused request so it is never taken twice
	task automatic push(input otp_prog_pkg::op_t op, input logic [12:0] a, input logic [7:0] d,
		input bit may_refuse);
		int n;
		n = 0;
		@(posedge clock);
		cmd <= '{op, a, d};
		cmd_valid <= 1;
		do @(negedge clock); while (cmd_ready !== 1'b1 && ++n < 300);
		@(posedge clock);
		cmd_valid <= 0;
		ok = (n < 300);
		if (!ok && !may_refuse) begin
			error_cnt++;
			final_report();
		end
	endtask
	task automatic pull();
		int n;
		n = 0;
		@(posedge clock);
		result_ready <= 1;
		do @(negedge clock); while (result_valid !== 1'b1 && ++n < 3000);
		r = result;
		@(posedge clock);
		result_ready <= 0;
		if (n == 3000) begin
			error_cnt++;
			final_report();
		end
	endtask
	task automatic t_erased();
		for (k = 0; k < 2; k++) begin
			push(otp_prog_pkg::op_verify, k ? 13'h1fff : 13'h0000, 8'h00, 0);
			repeat (10) @(negedge clock);
			chk("busy", 32'(busy), 32'h1);
			pull();
			@(negedge clock);
			chk("idle", 32'(busy), 32'h0);
			chk("addr", 32'(r.addr), k ? 32'h1fff : 32'h0000);
			chk("erased data", 32'(r.data), 32'hff);
			chk("erased flag", 32'(r.erased), 32'h1);
		end
	endtask
	// Program and verify queued back to back, at address 0x0005 and at the top of the array
	task automatic t_program();
		for (k = 0; k < 2; k++) begin
			push(otp_prog_pkg::op_program, k ? 13'h1fff : 13'h0005, k ? 8'h00 : 8'ha5, 0);
			push(otp_prog_pkg::op_verify, k ? 13'h1fff : 13'h0005, 8'h00, 0);
			pull();
			chk("readback", 32'(r.data), k ? 32'h00 : 32'ha5);
			chk("mismatch", 32'(r.mismatch), 32'h0);
			pull();
			chk("verify", 32'(r.data), k ? 32'h00 : 32'ha5);
			chk("not erased", 32'(r.erased), 32'h0);
		end
		// A programmed cell only loses ones, so a conflicting byte must be flagged
		push(otp_prog_pkg::op_program, 13'h0005, 8'h0f, 0);
		pull();
		chk("overwrite", 32'(r.data), 32'h05);
		chk("flagged", 32'(r.mismatch), 32'h1);
	endtask
	// Fills the queue behind one command that waits on its result
	task automatic t_fill();
		int i;
		k = 0;
		do begin
			push(otp_prog_pkg::op_verify, 13'(k + 16), 8'h00, 1);
			k++;
		end while (ok && k < 40);
		@(negedge clock);
		chk("full", 32'(cmd_ready), 32'h0);
		chk("depth", k - 1, `FIFO_DEPTH + 1);
		for (i = 0; i < k - 1; i++) begin
			pull();
			chk("order", 32'(r.addr), 32'(i + 16));
			chk("drain", 32'(r.data), 32'hff);
		end
	endtask
	initial begin
		repeat (5) @(posedge clock);
		reset_n <= 1;
		t_erased();
		t_program();
		t_fill();
		final_report();
	end
endmodule
